//--- phss_defines.svh
// phss_defines.svh: offsets, bit positions and reset values of the status block
// assumes: included by bare name from each file that needs it
`ifndef PHSS_DEFINES_SVH
`define PHSS_DEFINES_SVH

// ------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------
`define PHSS_IDX_BSTS      6'h01
`define PHSS_IDX_ANEX      6'h06
`define PHSS_IDX_STATUS    6'h10
`define PHSS_IDX_ISRC      6'h12
`define PHSS_IDX_EVT_STAT  6'h20
`define PHSS_IDX_EVT_CLR   6'h21
`define PHSS_IDX_EVT_EN    6'h22

// ------------------------------------------------------------
// summary status bit positions
// ------------------------------------------------------------
`define PHSS_B_SIGDET   10
`define PHSS_B_LOCK     9
`define PHSS_B_PAGE     8
`define PHSS_B_INT      7
`define PHSS_B_RFAULT   6
`define PHSS_B_JABBER   5
`define PHSS_B_ANDONE   4
`define PHSS_B_LOOP     3
`define PHSS_B_DUPLEX   2
`define PHSS_B_SPEED    1
`define PHSS_B_LINK     0
`define PHSS_RSVD_HI    15
`define PHSS_RSVD_LO    11

// bits of the companion registers
`define PHSS_ANEX_PAGE  1
`define PHSS_BSTS_JAB   1
`define PHSS_BSTS_LINK  2
`define PHSS_BSTS_RF    4

// ------------------------------------------------------------
// raw input vector positions
// ------------------------------------------------------------
`define PHSS_I_SIGDET   0
`define PHSS_I_LOCK     1
`define PHSS_I_PAGE     2
`define PHSS_I_INT      3
`define PHSS_I_RFAULT   4
`define PHSS_I_JABBER   5
`define PHSS_I_ANDONE   6
`define PHSS_I_ANEN     7
`define PHSS_I_LOOP     8
`define PHSS_I_DUPLEX   9
`define PHSS_I_SPEED    10
`define PHSS_I_LINK     11
`define PHSS_NUM_IN     12

// ------------------------------------------------------------
// event bits of the interrupt registers
// ------------------------------------------------------------
`define PHSS_E_PAGE     0
`define PHSS_E_RFAULT   1
`define PHSS_E_LINKDN   2
`define PHSS_E_JABBER   3
`define PHSS_NUM_EVT    4

`define PHSS_RST_WORD   32'h0000_0000
`define PHSS_RST_EVT    4'h0

`endif

//--- phss_pkg.sv
// phss_pkg.sv: types shared by the status block
// assumes: constants come from phss_defines.svh
`include "phss_defines.svh"

package phss_pkg;
  typedef logic [31:0]               phss_word_t;
  typedef logic [15:0]               phss_half_t;
  typedef logic [`PHSS_NUM_EVT-1:0]  phss_evt_t;
  typedef logic [`PHSS_NUM_IN-1:0]   phss_in_t;
endpackage : phss_pkg

//--- phss_sync.sv
// phss_sync.sv: two flip-flop synchroniser for a vector of independent levels
// assumes: each bit is a slow level; bits are not sampled as a coherent word
`timescale 1ns/1ps
`include "phss_defines.svh"

module phss_sync
  import phss_pkg::*;
#(
  parameter int W = `PHSS_NUM_IN
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_bad_width
    $error("phss_sync: W must be at least 1");
  end

  // meta is read only by sync_out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : phss_sync

//--- phss_status.sv
// phss_status.sv: summary status register of a 10/100 transceiver with its
// companion read-to-clear registers, an event interrupt and an APB slave
// assumes: status sources are pins from other clock domains; one clock pclk
// Notes on behaviour
// R1: bit 10 shows the 100 Mb/s signal detect, active high, read-only and latching low.
// R2: bit 9 shows the 100 Mb/s descrambler lock, active high, read-only and latching low.
// R3: bit 8 copies the page-received flag, cleared by reading the autoneg expansion register only.
// R4: bit 7 is 1 while an internal interrupt is pending; reading the interrupt source register clears it.
// R5: bit 6 is set by a partner remote fault and cleared by a basic mode status read or reset.
// R6: bit 5 copies the jabber flag, meaningful at 10 Mb/s only, and is not cleared by reading.
// R7: bit 4 is 1 once auto-negotiation has completed, else 0.
// R8: bit 3 is 1 while interface loopback is active, else 0.
// R9: bit 2 is 1 for full duplex, valid with link and negotiation done or disabled.
// R10: bit 1 is 1 for 10 Mb/s and 0 for 100 Mb/s, with the same validity as bit 2.
// R11: bit 0 is 1 with a valid link, copies the link flag and is not cleared by reading.
// R12: writes to the summary status register are ignored.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "phss_defines.svh"

module phss_status
  import phss_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sig_detect,
  input  wire logic              descr_lock,
  input  wire logic              page_rx,
  input  wire logic              int_event,
  input  wire logic              remote_fault,
  input  wire logic              jabber,
  input  wire logic              an_done,
  input  wire logic              an_enable,
  input  wire logic              mii_loopback,
  input  wire logic              full_duplex,
  input  wire logic              speed_10,
  input  wire logic              link_up,
  output logic                   irq
);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("phss_status: ADDR_W must be at least 8");
  end

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  wire logic [`PHSS_NUM_IN-1:0] raw_in;
  phss_in_t                     s_in;

  assign raw_in[`PHSS_I_SIGDET] = sig_detect;
  assign raw_in[`PHSS_I_LOCK]   = descr_lock;
  assign raw_in[`PHSS_I_PAGE]   = page_rx;
  assign raw_in[`PHSS_I_INT]    = int_event;
  assign raw_in[`PHSS_I_RFAULT] = remote_fault;
  assign raw_in[`PHSS_I_JABBER] = jabber;
  assign raw_in[`PHSS_I_ANDONE] = an_done;
  assign raw_in[`PHSS_I_ANEN]   = an_enable;
  assign raw_in[`PHSS_I_LOOP]   = mii_loopback;
  assign raw_in[`PHSS_I_DUPLEX] = full_duplex;
  assign raw_in[`PHSS_I_SPEED]  = speed_10;
  assign raw_in[`PHSS_I_LINK]   = link_up;

  phss_sync #(
    .W        (`PHSS_NUM_IN)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_in),
    .sync_out (s_in)
  );

  wire logic sd_s   = s_in[`PHSS_I_SIGDET];
  wire logic lock_s = s_in[`PHSS_I_LOCK];
  wire logic page_s = s_in[`PHSS_I_PAGE];
  wire logic int_s  = s_in[`PHSS_I_INT];
  wire logic rf_s   = s_in[`PHSS_I_RFAULT];
  wire logic jab_s  = s_in[`PHSS_I_JABBER];
  wire logic and_s  = s_in[`PHSS_I_ANDONE];
  wire logic ane_s  = s_in[`PHSS_I_ANEN];
  wire logic loop_s = s_in[`PHSS_I_LOOP];
  wire logic dup_s  = s_in[`PHSS_I_DUPLEX];
  wire logic spd_s  = s_in[`PHSS_I_SPEED];
  wire logic link_s = s_in[`PHSS_I_LINK];

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire logic [5:0] idx      = paddr[7:2];
  wire logic       setup    = psel && !penable;
  wire logic       access   = psel && penable;
  wire logic       rd_take  = setup && !pwrite;
  wire logic       wr_done  = access && pwrite;
  wire logic       hit_sts  = (idx == `PHSS_IDX_STATUS);
  wire logic       hit_bsts = (idx == `PHSS_IDX_BSTS);
  wire logic       hit_anex = (idx == `PHSS_IDX_ANEX);
  wire logic       hit_isrc = (idx == `PHSS_IDX_ISRC);
  wire logic       hit_est  = (idx == `PHSS_IDX_EVT_STAT);
  wire logic       hit_ecl  = (idx == `PHSS_IDX_EVT_CLR);
  wire logic       hit_een  = (idx == `PHSS_IDX_EVT_EN);
  wire logic       mapped   = hit_sts || hit_bsts || hit_anex || hit_isrc
                              || hit_est || hit_ecl || hit_een;

  // read side effects act at the setup edge, where the read word is captured:
  // an event landing between capture and clear would otherwise be lost
  wire logic sts_rd  = rd_take && hit_sts;
  wire logic bsts_rd = rd_take && hit_bsts;
  wire logic anex_rd = rd_take && hit_anex;
  wire logic isrc_rd = rd_take && hit_isrc;

  // no wait state: read data is registered in setup, so pready is high in the first access cycle
  assign pready = access;

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  logic sd_ll;
  logic lock_ll;
  logic page_flag;
  logic int_pend;
  logic rf_flag;
  logic page_prev;
  logic int_prev;
  logic link_prev;
  logic jab_prev;

  wire logic page_set = page_s && !page_prev;
  wire logic int_set  = int_s && !int_prev;

  // latch low: a drop holds 0 until the summary is read, then the live level returns
  wire logic next_sd_ll   = sts_rd ? sd_s : (sd_ll && sd_s);        // [R1]
  wire logic next_lock_ll = sts_rd ? lock_s : (lock_ll && lock_s);  // [R2]
  // set wins over a clear in the same cycle
  wire logic next_page    = page_set || (page_flag && !anex_rd);    // [R3]
  wire logic next_int     = int_set || (int_pend && !isrc_rd);      // [R4]
  wire logic next_rf      = rf_s || (rf_flag && !bsts_rd);          // [R5]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_ll     <= 1'b0;
      lock_ll   <= 1'b0;
      page_flag <= 1'b0;
      int_pend  <= 1'b0;
      rf_flag   <= 1'b0;
    end else begin
      sd_ll     <= next_sd_ll;
      lock_ll   <= next_lock_ll;
      page_flag <= next_page;
      int_pend  <= next_int;
      rf_flag   <= next_rf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_prev <= 1'b0;
      int_prev  <= 1'b0;
      link_prev <= 1'b0;
      jab_prev  <= 1'b0;
    end else begin
      page_prev <= page_s;
      int_prev  <= int_s;
      link_prev <= link_s;
      jab_prev  <= jab_s;
    end
  end

  // duplex and speed are shown only while they mean something, else 0
  wire logic mode_valid = link_s && (and_s || !ane_s);

  // ------------------------------------------------------------
  // register words
  // ------------------------------------------------------------
  wire logic [15:0] sts_word;
  assign sts_word[`PHSS_RSVD_HI:`PHSS_RSVD_LO] = '0;
  assign sts_word[`PHSS_B_SIGDET] = sd_ll;                    // [R1]
  assign sts_word[`PHSS_B_LOCK]   = lock_ll;                  // [R2]
  assign sts_word[`PHSS_B_PAGE]   = page_flag;                // [R3]
  assign sts_word[`PHSS_B_INT]    = int_pend;                 // [R4]
  assign sts_word[`PHSS_B_RFAULT] = rf_flag;                  // [R5]
  assign sts_word[`PHSS_B_JABBER] = jab_s;                    // [R6]
  assign sts_word[`PHSS_B_ANDONE] = and_s;                    // [R7]
  assign sts_word[`PHSS_B_LOOP]   = loop_s;                   // [R8]
  assign sts_word[`PHSS_B_DUPLEX] = mode_valid && dup_s;      // [R9]
  assign sts_word[`PHSS_B_SPEED]  = mode_valid && spd_s;      // [R10]
  assign sts_word[`PHSS_B_LINK]   = link_s;                   // [R11]

  logic [15:0] bsts_word;
  logic [15:0] anex_word;
  logic [15:0] isrc_word;
  always_comb begin
    bsts_word                  = '0;
    bsts_word[`PHSS_BSTS_JAB]  = jab_s;                       // [R6]
    bsts_word[`PHSS_BSTS_LINK] = link_s;                      // [R11]
    bsts_word[`PHSS_BSTS_RF]   = rf_flag;
    anex_word                  = '0;
    anex_word[`PHSS_ANEX_PAGE] = page_flag;
    isrc_word                  = '0;
    isrc_word[`PHSS_B_INT]     = int_pend;
  end

  // ------------------------------------------------------------
  // event interrupt
  // ------------------------------------------------------------
  phss_evt_t evt_stat;
  phss_evt_t evt_en;
  wire phss_evt_t evt_hit;

  assign evt_hit[`PHSS_E_PAGE]   = page_set;
  assign evt_hit[`PHSS_E_RFAULT] = rf_s && !rf_flag;
  assign evt_hit[`PHSS_E_LINKDN] = link_prev && !link_s;
  assign evt_hit[`PHSS_E_JABBER] = jab_s && !jab_prev;

  wire logic      ecl_wr   = wr_done && hit_ecl;
  wire logic      een_wr   = wr_done && hit_een;
  wire phss_evt_t ecl_mask = ecl_wr ? pwdata[`PHSS_NUM_EVT-1:0] : '0;
  // a new event beats a write-one-to-clear in the same cycle
  wire phss_evt_t next_evt_stat = evt_hit | (evt_stat & ~ecl_mask);
  wire phss_evt_t next_evt_en   = een_wr ? pwdata[`PHSS_NUM_EVT-1:0] : evt_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat <= `PHSS_RST_EVT;
      evt_en   <= `PHSS_RST_EVT;
    end else begin
      evt_stat <= next_evt_stat;
      evt_en   <= next_evt_en;
    end
  end

  assign irq = |(evt_stat & evt_en);

  // ------------------------------------------------------------
  // read data and error
  // ------------------------------------------------------------
  // writes to every read-only word, the summary among them, are dropped
  // silently; only the two event registers above take write data   [R12]
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `PHSS_RST_WORD;
    unique case (1'b1)
      hit_sts:  rd_mux[15:0] = sts_word;
      hit_bsts: rd_mux[15:0] = bsts_word;
      hit_anex: rd_mux[15:0] = anex_word;
      hit_isrc: rd_mux[15:0] = isrc_word;
      hit_est:  rd_mux[`PHSS_NUM_EVT-1:0] = evt_stat;
      hit_een:  rd_mux[`PHSS_NUM_EVT-1:0] = evt_en;
      default:  rd_mux = `PHSS_RST_WORD;
    endcase
  end

  wire logic [31:0] next_prdata  = (setup && !pwrite) ? rd_mux : prdata;
  wire logic        next_pslverr = setup ? !mapped : pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `PHSS_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sts_setup;
    psel && !penable && !pwrite && hit_sts;
  endsequence

  sequence s_sts_access;
    psel && penable && pready;
  endsequence

  property p_sd_latch;
    !sd_s ##1 (sd_s && !sts_rd) |=> !sts_word[`PHSS_B_SIGDET];
  endproperty
  a_sd_latch: assert property (p_sd_latch) else $error("signal detect did not latch low"); // [R1]

  property p_lock_rearm;
    (sts_rd && lock_s) ##1 (lock_s && !sts_rd) |-> sts_word[`PHSS_B_LOCK];
  endproperty
  a_lock_rearm: assert property (p_lock_rearm) else $error("lock bit not rearmed by read"); // [R2]

  property p_page_clear;
    (anex_rd && !page_set) ##1 !page_set |-> !sts_word[`PHSS_B_PAGE];
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page bit survived expansion read"); // [R3]

  property p_page_sts_keep;
    (page_flag && sts_rd) |=> page_flag;
  endproperty
  a_page_sts_keep: assert property (p_page_sts_keep) else $error("page bit cleared by summary read"); // [R3]

  property p_int_hold;
    int_set ##1 (!isrc_rd)[*2] |-> sts_word[`PHSS_B_INT];
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt pending lost"); // [R4]

  property p_rf_clear;
    (bsts_rd && !rf_s) |=> !rf_flag;
  endproperty
  a_rf_clear: assert property (p_rf_clear) else $error("remote fault not cleared by read"); // [R5]

  property p_jab_read;
    s_sts_setup ##1 s_sts_access |-> prdata[`PHSS_B_JABBER] == $past(jab_s, 1);
  endproperty
  a_jab_read: assert property (p_jab_read) else $error("jabber bit wrong on read"); // [R6]

  property p_andone_read;
    s_sts_setup ##1 s_sts_access |-> prdata[`PHSS_B_ANDONE] == $past(and_s, 1);
  endproperty
  a_andone_read: assert property (p_andone_read) else $error("negotiation done bit wrong"); // [R7]

  property p_loop_read;
    s_sts_setup ##1 s_sts_access |-> prdata[`PHSS_B_LOOP] == $past(loop_s, 1);
  endproperty
  a_loop_read: assert property (p_loop_read) else $error("loopback bit wrong"); // [R8]

  property p_mode_invalid;
    s_sts_setup ##1 s_sts_access |-> ($past(link_s, 1) && ($past(and_s, 1) || !$past(ane_s, 1)))
                                     || (!prdata[`PHSS_B_DUPLEX] && !prdata[`PHSS_B_SPEED]);
  endproperty
  a_mode_invalid: assert property (p_mode_invalid) else $error("duplex or speed shown without valid link"); // [R9]

  property p_speed_valid;
    s_sts_setup ##1 s_sts_access |-> !($past(link_s, 1) && !$past(ane_s, 1))
                                     || (prdata[`PHSS_B_SPEED] == $past(spd_s, 1));
  endproperty
  a_speed_valid: assert property (p_speed_valid) else $error("speed bit wrong with valid link"); // [R10]

  property p_link_keep;
    s_sts_setup ##1 s_sts_access |-> prdata[`PHSS_B_LINK] == $past(link_s, 1);
  endproperty
  a_link_keep: assert property (p_link_keep) else $error("link bit cleared by read"); // [R11]

  property p_sts_write;
    (setup && pwrite && hit_sts) ##1 wr_done |=> $stable(evt_en) && !pslverr;
  endproperty
  a_sts_write: assert property (p_sts_write) else $error("summary write had an effect"); // [R12]

endmodule : phss_status

//--- tb_top.sv
// tb_top.sv: self-checking bench for the summary status block and its apb slave
// assumes: phss_defines.svh and phss_pkg are compiled first; one 40 MHz clock
`timescale 1ns/1ps
`include "phss_defines.svh"

module tb_top
  import phss_pkg::*;
;
  // ------------------------------------------------------------
  // signals and addresses
  // ------------------------------------------------------------
  localparam logic [7:0] A_BSTS = {`PHSS_IDX_BSTS, 2'b00};
  localparam logic [7:0] A_ANEX = {`PHSS_IDX_ANEX, 2'b00};
  localparam logic [7:0] A_STAT = {`PHSS_IDX_STATUS, 2'b00};
  localparam logic [7:0] A_ISRC = {`PHSS_IDX_ISRC, 2'b00};
  localparam logic [7:0] A_EVS  = {`PHSS_IDX_EVT_STAT, 2'b00};
  localparam logic [7:0] A_EVC  = {`PHSS_IDX_EVT_CLR, 2'b00};
  localparam logic [7:0] A_EVE  = {`PHSS_IDX_EVT_EN, 2'b00};
  logic       pclk;
  logic       presetn;
  logic       psel;
  logic       penable;
  logic       pwrite;
  logic [7:0] paddr;
  phss_word_t pwdata;
  phss_word_t prdata;
  logic       pready;
  logic       pslverr;
  logic       irq;
  phss_in_t   stim;
  phss_word_t rdat;
  logic       rerr;
  logic       valid;
  int         fails;
  int         checks_done;

  phss_status #(.ADDR_W(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sig_detect(stim[`PHSS_I_SIGDET]), .descr_lock(stim[`PHSS_I_LOCK]),
    .page_rx(stim[`PHSS_I_PAGE]), .int_event(stim[`PHSS_I_INT]),
    .remote_fault(stim[`PHSS_I_RFAULT]), .jabber(stim[`PHSS_I_JABBER]),
    .an_done(stim[`PHSS_I_ANDONE]), .an_enable(stim[`PHSS_I_ANEN]),
    .mii_loopback(stim[`PHSS_I_LOOP]), .full_duplex(stim[`PHSS_I_DUPLEX]),
    .speed_10(stim[`PHSS_I_SPEED]), .link_up(stim[`PHSS_I_LINK]), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // compare, bus and stimulus tasks
  // ------------------------------------------------------------
  task automatic chk_word(input phss_word_t got, input phss_word_t exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // request held until pready is seen high; the bench timeout ends a hang
  task automatic apb(input logic wr, input logic [7:0] addr, input phss_word_t wd,
                     output phss_word_t rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] addr, input phss_word_t mask, input phss_word_t exp);
    apb(1'b0, addr, 32'h0, rdat, rerr);
    chk_bit(rerr, 1'b0);
    chk_word(rdat & mask, exp);
  endtask : rd_chk

  task automatic wr(input logic [7:0] addr, input phss_word_t data);
    apb(1'b1, addr, data, rdat, rerr);
  endtask : wr

  // four edges cover the two-stage synchroniser plus the flag update
  task automatic set_in(input int idx, input logic val);
    @(posedge pclk);
    stim[idx] <= val;
    repeat (4) @(posedge pclk);
  endtask : set_in

  task automatic pulse_in(input int idx);
    set_in(idx, 1'b1);
    set_in(idx, 1'b0);
  endtask : pulse_in

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic end_sim();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    fails = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stim = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    // latch-low: first read shows the reset 0, the next shows the live level
    set_in(`PHSS_I_SIGDET, 1'b1);
    set_in(`PHSS_I_LOCK, 1'b1);
    rd_chk(A_STAT, 32'h0000_0600, 32'h0000_0000);
    rd_chk(A_STAT, 32'h0000_0600, 32'h0000_0600);
    pulse_in(`PHSS_I_SIGDET);
    set_in(`PHSS_I_SIGDET, 1'b1);
    rd_chk(A_STAT, 32'h0000_0600, 32'h0000_0200);
    rd_chk(A_STAT, 32'h0000_0600, 32'h0000_0600);
    pulse_in(`PHSS_I_LOCK);
    set_in(`PHSS_I_LOCK, 1'b1);
    rd_chk(A_STAT, 32'h0000_0600, 32'h0000_0400);
    rd_chk(A_STAT, 32'hFFFF_FFFF, 32'h0000_0600);
    wr(A_STAT, 32'hFFFF_FFFF);
    chk_bit(rerr, 1'b0);
    rd_chk(A_STAT, 32'hFFFF_FFFF, 32'h0000_0600);
    // page flag survives summary reads, cleared by the expansion read
    pulse_in(`PHSS_I_PAGE);
    rd_chk(A_STAT, 32'h0000_0100, 32'h0000_0100);
    rd_chk(A_STAT, 32'h0000_0100, 32'h0000_0100);
    rd_chk(A_ANEX, 32'h0000_0002, 32'h0000_0002);
    rd_chk(A_STAT, 32'h0000_0100, 32'h0000_0000);
    pulse_in(`PHSS_I_INT);
    rd_chk(A_STAT, 32'h0000_0080, 32'h0000_0080);
    rd_chk(A_ISRC, 32'h0000_0080, 32'h0000_0080);
    rd_chk(A_STAT, 32'h0000_0080, 32'h0000_0000);
    pulse_in(`PHSS_I_RFAULT);
    rd_chk(A_STAT, 32'h0000_0040, 32'h0000_0040);
    rd_chk(A_BSTS, 32'h0000_0010, 32'h0000_0010);
    rd_chk(A_STAT, 32'h0000_0040, 32'h0000_0000);
    set_in(`PHSS_I_JABBER, 1'b1);
    rd_chk(A_STAT, 32'h0000_0020, 32'h0000_0020);
    rd_chk(A_STAT, 32'h0000_0020, 32'h0000_0020);
    rd_chk(A_BSTS, 32'h0000_0002, 32'h0000_0002);
    set_in(`PHSS_I_JABBER, 1'b0);
    rd_chk(A_STAT, 32'h0000_0020, 32'h0000_0000);
    set_in(`PHSS_I_LOOP, 1'b1);
    rd_chk(A_STAT, 32'h0000_0008, 32'h0000_0008);
    set_in(`PHSS_I_LOOP, 1'b0);
    rd_chk(A_STAT, 32'h0000_0008, 32'h0000_0000);
    // every mix of link, negotiation and forced duplex/speed
    for (int i = 0; i < 32; i++) begin
      @(posedge pclk);
      stim[`PHSS_I_LINK]   <= i[4];
      stim[`PHSS_I_ANEN]   <= i[3];
      stim[`PHSS_I_ANDONE] <= i[2];
      stim[`PHSS_I_DUPLEX] <= i[1];
      stim[`PHSS_I_SPEED]  <= i[0];
      repeat (4) @(posedge pclk);
      valid = i[4] & (~i[3] | i[2]);
      rd_chk(A_STAT, 32'h0000_0017, {27'h0, i[2], 1'b0, valid & i[1], valid & i[0], i[4]});
      rd_chk(A_BSTS, 32'h0000_0004, {29'h0, i[4], 2'b00});
    end
    // event interrupt: raise, mask, clear
    wr(A_EVC, 32'h0000_000F);
    rd_chk(A_EVS, 32'h0000_000F, 32'h0000_0000);
    pulse_in(`PHSS_I_PAGE);
    rd_chk(A_EVS, 32'h0000_0001, 32'h0000_0001);
    chk_bit(irq, 1'b0);
    wr(A_EVE, 32'h0000_0001);
    @(negedge pclk);
    chk_bit(irq, 1'b1);
    rd_chk(A_EVE, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(A_EVE, 32'h0000_0000);
    @(negedge pclk);
    chk_bit(irq, 1'b0);
    wr(A_EVE, 32'h0000_0001);
    wr(A_EVC, 32'h0000_0001);
    @(negedge pclk);
    chk_bit(irq, 1'b0);
    rd_chk(A_EVS, 32'h0000_0001, 32'h0000_0000);
    rd_chk(A_EVC, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 8'hF0, 32'h0, rdat, rerr);
    chk_bit(rerr, 1'b1);
    chk_word(rdat, 32'h0000_0000);
    // reset in mid-run drops a pending remote fault
    pulse_in(`PHSS_I_RFAULT);
    rd_chk(A_STAT, 32'h0000_0040, 32'h0000_0040);
    do_reset();
    rd_chk(A_STAT, 32'h0000_0040, 32'h0000_0000);
    end_sim();
  end
endmodule : tb_top
